// *** logic/nvmac_defines.svh ***
// Purpose: constants for the nonvolatile access controller
// Assumes: byte-wide special function register port
// Notes:   definitions only
`ifndef NVMAC_DEFINES_SVH
`define NVMAC_DEFINES_SVH
`define NVMAC_ADR_PERIPHERAL_IRQ_PRIORITY_TWO     12'hFA2
`define NVMAC_ADR_CTRL     12'hFA6
`define NVMAC_ADR_KEY      12'hFA7
`define NVMAC_ADR_DATA     12'hFA8
`define NVMAC_ADR_ADRL     12'hFA9
`define NVMAC_ADR_ADRH     12'hFAA
`define NVMAC_ADR_TLAT     12'hFF5
`define NVMAC_ADR_TPL      12'hFF6
`define NVMAC_ADR_TPH      12'hFF7
`define NVMAC_ADR_TPU      12'hFF8
`define NVMAC_KEY1         8'h55
`define NVMAC_KEY2         8'hAA
`define NVMAC_B_MSEL       7
`define NVMAC_B_CONFIG_SPACE_SELECT       6
`define NVMAC_B_FREE       4
`define NVMAC_B_WERR       3
`define NVMAC_B_WRITE_ENABLE       2
`define NVMAC_B_WR         1
`define NVMAC_B_RD         0
`define NVMAC_B_PRIO       4
`define NVMAC_PERIPHERAL_IRQ_PRIORITY_TWO_RST     8'h5F
`define NVMAC_PERIPHERAL_IRQ_PRIORITY_TWO_MASK    8'h5F
`define NVMAC_CTRL_MASK    8'hDF
`define NVMAC_HOLD_ERASED  8'hFF
`define NVMAC_WRITE_NS     2000
`define NVMAC_CLK_NS       10
`endif

// *** logic/nvmac_pkg.sv ***
// Purpose: types for the nonvolatile access controller
// Assumes: nothing
// Notes:   key sequence states one-hot
package nvmac_pkg;
  typedef enum logic [2:0] {
    NVMAC_K_IDLE = 3'b001,
    NVMAC_K_GOT1 = 3'b010,
    NVMAC_K_ARM  = 3'b100
  } nvmac_key_e;
endpackage

// *** logic/nvmac_top.sv ***
// Purpose: data EEPROM and flash access control registers with self-timed writes
// Assumes: one register access per CLK, memory arrays live outside
// Notes:   WRITE_CYCLES shortens the self-timed write in simulation
// Functional notes
// - table read moves one byte from pointer address to latch; table write moves latch into holding register.
// - read byte lands in data register before next instruction cycle.
// - data register holds read byte until next read or software write.
// - write starts only after 55h then AAh to unlock, then write bit.
// - write bit cannot be set unless write enable is already set.
// - write bit and write enable in one write do not start a write.
// - hardware clears write enable only on abort reset.
// - control, address and data registers locked while write runs.
// - write end clears write bit and sets write-complete flag.
// - write-complete flag stays until software clears it.
// - software can only set write bit; hardware clears it at end.
// - write-complete flag sets regardless of its enable bits.
// - program erase acts on 64-byte block at pointer base.
// - table write only loads holding register; long write on write bit.
// - holding register is 8 bytes; one write cycle commits a group.
`timescale 1ns/1ns
`default_nettype none
`include "nvmac_defines.svh"
module nvmac_top
  import nvmac_pkg::*;
#(
  parameter int WRITE_CYCLES = (`NVMAC_WRITE_NS + `NVMAC_CLK_NS - 1) / `NVMAC_CLK_NS,
  parameter int HOLD_BYTES   = 8,
  parameter int BLOCK_BYTES  = 64
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic        ABORT_RST,
  input  wire logic [11:0] SFR_ADDR,
  input  wire logic        SFR_WE,
  input  wire logic [7:0]  SFR_WDATA,
  output logic      [7:0]  SFR_RDATA,
  input  wire logic        TBL_RD,
  input  wire logic        TBL_WR,
  output logic      [21:0] PGM_ADDR,
  input  wire logic [7:0]  PGM_RDATA,
  input  wire logic [7:0]  EE_RDATA,
  output logic      [9:0]  EE_ADDR,
  output logic      [7:0]  EE_WDATA,
  output logic             NVM_BUSY,
  output logic             EE_WRITE_START,
  output logic             PGM_WRITE_START,
  output logic             PGM_ERASE_START,
  output logic      [63:0] HOLD_DATA,
  output logic             WRITE_DONE_FLAG,
  output logic             WRITE_DONE_PRIO
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);
  localparam int HW = $clog2(HOLD_BYTES);
  localparam int BW = $clog2(BLOCK_BYTES);

  logic [7:0]  ctrl_q;
  logic [7:0]  data_q;
  logic [7:0]  adrl_q;
  logic [1:0]  adrh_q;
  logic [7:0]  tlat_q;
  logic [21:0] tptr_q;
  logic [7:0]  peripheral_irq_priority_two_q;
  logic        write_complete_flag_q;
  logic [CW-1:0] cnt_q;
  logic [7:0]  hold_q [HOLD_BYTES];
  nvmac_key_e  key_q;
  logic        busy;
  logic        wr_ctrl;
  logic        start;
  logic        done;
  logic        rd_go;

  assign busy    = ctrl_q[`NVMAC_B_WR];
  assign wr_ctrl = SFR_WE && SFR_ADDR == `NVMAC_ADR_CTRL && !busy;
  // write enable must already be set; same-write setting is refused
  assign start   = wr_ctrl && SFR_WDATA[`NVMAC_B_WR] && ctrl_q[`NVMAC_B_WRITE_ENABLE]
                   && key_q == NVMAC_K_ARM;
  assign done    = busy && cnt_q == CW'(1);
  assign rd_go   = wr_ctrl && SFR_WDATA[`NVMAC_B_RD];

  // unlock key sequence; any other register write breaks it
  // abort comes from the core's own reset logic on CLK, so no synchroniser
  always_ff @(posedge CLK) begin
    if (!RESETN || ABORT_RST) begin
      key_q <= NVMAC_K_IDLE;
    end else if (SFR_WE) begin
      case (key_q)
        NVMAC_K_IDLE: key_q <= (SFR_ADDR == `NVMAC_ADR_KEY && SFR_WDATA == `NVMAC_KEY1)
                               ? NVMAC_K_GOT1 : NVMAC_K_IDLE;
        NVMAC_K_GOT1: key_q <= (SFR_ADDR == `NVMAC_ADR_KEY && SFR_WDATA == `NVMAC_KEY2)
                               ? NVMAC_K_ARM : NVMAC_K_IDLE;
        NVMAC_K_ARM:  key_q <= NVMAC_K_IDLE;
        default:      key_q <= NVMAC_K_IDLE;
      endcase
    end
  end

  // control register
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_q <= 8'h00;
    end else if (ABORT_RST) begin
      // only write-related bits reset so the failed operation can be traced
      ctrl_q[`NVMAC_B_WERR] <= ctrl_q[`NVMAC_B_WERR] | busy;
      ctrl_q[`NVMAC_B_WR]   <= 1'b0;
      ctrl_q[`NVMAC_B_RD]   <= 1'b0;
      ctrl_q[`NVMAC_B_WRITE_ENABLE] <= 1'b0;
    end else if (done) begin
      ctrl_q[`NVMAC_B_WR]   <= 1'b0;
      if (ctrl_q[`NVMAC_B_MSEL]) begin
        ctrl_q[`NVMAC_B_FREE] <= 1'b0;
      end
    end else if (wr_ctrl) begin
      ctrl_q[`NVMAC_B_MSEL] <= SFR_WDATA[`NVMAC_B_MSEL];
      ctrl_q[`NVMAC_B_CONFIG_SPACE_SELECT] <= SFR_WDATA[`NVMAC_B_CONFIG_SPACE_SELECT];
      ctrl_q[`NVMAC_B_FREE] <= SFR_WDATA[`NVMAC_B_FREE];
      ctrl_q[`NVMAC_B_WERR] <= SFR_WDATA[`NVMAC_B_WERR];
      ctrl_q[`NVMAC_B_WRITE_ENABLE] <= SFR_WDATA[`NVMAC_B_WRITE_ENABLE];
      ctrl_q[`NVMAC_B_WR]   <= start;
      // single-cycle read: bit never seen high by software
      ctrl_q[`NVMAC_B_RD]   <= 1'b0;
    end
  end

  // self-timed write counter
  always_ff @(posedge CLK) begin
    if (!RESETN || ABORT_RST) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= CW'(WRITE_CYCLES);
    end else if (busy && cnt_q != '0) begin
      cnt_q <= cnt_q - CW'(1);
    end
  end

  // completion flag: set wins over software clear
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      write_complete_flag_q <= 1'b0;
    end else if (done) begin
      write_complete_flag_q <= 1'b1;
    end else if (SFR_WE && SFR_ADDR == `NVMAC_ADR_PERIPHERAL_IRQ_PRIORITY_TWO && SFR_WDATA[`NVMAC_B_PRIO + 1]) begin
      write_complete_flag_q <= 1'b0;
    end
  end

  // data register, address pair, priority
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      data_q <= 8'h00;
      adrl_q <= 8'h00;
      adrh_q <= 2'b00;
      peripheral_irq_priority_two_q <= `NVMAC_PERIPHERAL_IRQ_PRIORITY_TWO_RST;
    end else begin
      if (rd_go && !SFR_WDATA[`NVMAC_B_MSEL] && !SFR_WDATA[`NVMAC_B_CONFIG_SPACE_SELECT]) begin
        data_q <= EE_RDATA;
      end else if (SFR_WE && SFR_ADDR == `NVMAC_ADR_DATA && !busy) begin
        data_q <= SFR_WDATA;
      end
      if (SFR_WE && SFR_ADDR == `NVMAC_ADR_ADRL && !busy) begin
        adrl_q <= SFR_WDATA;
      end
      if (SFR_WE && SFR_ADDR == `NVMAC_ADR_ADRH && !busy) begin
        adrh_q <= SFR_WDATA[1:0];
      end
      if (SFR_WE && SFR_ADDR == `NVMAC_ADR_PERIPHERAL_IRQ_PRIORITY_TWO) begin
        peripheral_irq_priority_two_q <= SFR_WDATA & `NVMAC_PERIPHERAL_IRQ_PRIORITY_TWO_MASK;
      end
    end
  end

  // table pointer, latch and holding register
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      tptr_q <= '0;
      tlat_q <= 8'h00;
      for (int i = 0; i < HOLD_BYTES; i++) begin
        hold_q[i] <= `NVMAC_HOLD_ERASED;
      end
    end else begin
      if (SFR_WE && SFR_ADDR == `NVMAC_ADR_TPL) tptr_q[7:0] <= SFR_WDATA;
      if (SFR_WE && SFR_ADDR == `NVMAC_ADR_TPH) tptr_q[15:8] <= SFR_WDATA;
      if (SFR_WE && SFR_ADDR == `NVMAC_ADR_TPU) tptr_q[21:16] <= SFR_WDATA[5:0];
      if (TBL_RD) begin
        tlat_q <= PGM_RDATA;
      end else if (SFR_WE && SFR_ADDR == `NVMAC_ADR_TLAT) begin
        tlat_q <= SFR_WDATA;
      end
      if (TBL_WR && !busy) begin
        hold_q[tptr_q[HW-1:0]] <= tlat_q;
      end
      // refill with erased value so a partly loaded group commits blank bytes
      if (done && ctrl_q[`NVMAC_B_MSEL] && !ctrl_q[`NVMAC_B_FREE]) begin
        for (int i = 0; i < HOLD_BYTES; i++) begin
          hold_q[i] <= `NVMAC_HOLD_ERASED;
        end
      end
    end
  end

  // register read mux
  always_comb begin
    case (SFR_ADDR)
      `NVMAC_ADR_PERIPHERAL_IRQ_PRIORITY_TWO: SFR_RDATA = peripheral_irq_priority_two_q;
      `NVMAC_ADR_CTRL: SFR_RDATA = ctrl_q & `NVMAC_CTRL_MASK;
      `NVMAC_ADR_DATA: SFR_RDATA = data_q;
      `NVMAC_ADR_ADRL: SFR_RDATA = adrl_q;
      `NVMAC_ADR_ADRH: SFR_RDATA = {6'h00, adrh_q};
      `NVMAC_ADR_TLAT: SFR_RDATA = tlat_q;
      `NVMAC_ADR_TPL:  SFR_RDATA = tptr_q[7:0];
      `NVMAC_ADR_TPH:  SFR_RDATA = tptr_q[15:8];
      `NVMAC_ADR_TPU:  SFR_RDATA = {2'b00, tptr_q[21:16]};
      default:         SFR_RDATA = 8'h00;
    endcase
  end

  always_comb begin
    for (int i = 0; i < HOLD_BYTES; i++) begin
      HOLD_DATA[8*i +: 8] = hold_q[i];
    end
  end

  // erase base aligned to block, write base aligned to holding group
  assign PGM_ADDR        = (busy && ctrl_q[`NVMAC_B_FREE]) ? {tptr_q[21:BW], BW'(0)} :
                           busy ? {tptr_q[21:HW], HW'(0)} : tptr_q;
  assign EE_ADDR         = {adrh_q, adrl_q};
  assign EE_WDATA        = data_q;
  assign NVM_BUSY        = busy;
  assign EE_WRITE_START  = start && !ctrl_q[`NVMAC_B_MSEL];
  assign PGM_WRITE_START = start && ctrl_q[`NVMAC_B_MSEL] && !ctrl_q[`NVMAC_B_FREE];
  assign PGM_ERASE_START = start && ctrl_q[`NVMAC_B_MSEL] && ctrl_q[`NVMAC_B_FREE];
  assign WRITE_DONE_FLAG = write_complete_flag_q;
  assign WRITE_DONE_PRIO = peripheral_irq_priority_two_q[`NVMAC_B_PRIO];

  // internal checks; an abort may legally cut a write short
  property p_lock;
    @(posedge CLK) disable iff (!RESETN)
      busy && !ABORT_RST |=> $stable(data_q) && $stable(adrl_q) && $stable(adrh_q);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed during write");
  property p_nokey;
    @(posedge CLK) disable iff (!RESETN) key_q != NVMAC_K_ARM |-> !start;
  endproperty
  a_nokey: assert property (p_nokey) else $error("write started without unlock");
  property p_write_enable;
    @(posedge CLK) disable iff (!RESETN) start |-> ctrl_q[`NVMAC_B_WRITE_ENABLE];
  endproperty
  a_write_enable: assert property (p_write_enable) else $error("write started without enable");
  property p_done;
    @(posedge CLK) disable iff (!RESETN || ABORT_RST) done |=> !busy && write_complete_flag_q;
  endproperty
  a_done: assert property (p_done) else $error("completion not signalled");
  property p_sticky;
    @(posedge CLK) disable iff (!RESETN)
      write_complete_flag_q && !(SFR_WE && SFR_ADDR == `NVMAC_ADR_PERIPHERAL_IRQ_PRIORITY_TWO) |=> write_complete_flag_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");
  property p_write_enable_keep;
    @(posedge CLK) disable iff (!RESETN || ABORT_RST)
      ctrl_q[`NVMAC_B_WRITE_ENABLE] && !wr_ctrl |=> ctrl_q[`NVMAC_B_WRITE_ENABLE];
  endproperty
  a_write_enable_keep: assert property (p_write_enable_keep) else $error("enable cleared by hardware");
  property p_rd;
    @(posedge CLK) disable iff (!RESETN) ##1 !ctrl_q[`NVMAC_B_RD];
  endproperty
  a_rd: assert property (p_rd) else $error("read bit stuck");
  property p_werr;
    @(posedge CLK) disable iff (!RESETN) busy && ABORT_RST |=> ctrl_q[`NVMAC_B_WERR];
  endproperty
  a_werr: assert property (p_werr) else $error("abort not flagged");
  property p_rdata;
    @(posedge CLK) disable iff (!RESETN)
      rd_go && !SFR_WDATA[`NVMAC_B_MSEL] && !SFR_WDATA[`NVMAC_B_CONFIG_SPACE_SELECT] |=> data_q == $past(EE_RDATA);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read byte not loaded");
  property p_tlat;
    @(posedge CLK) disable iff (!RESETN) TBL_RD |=> tlat_q == $past(PGM_RDATA);
  endproperty
  a_tlat: assert property (p_tlat) else $error("table latch not loaded");
  property p_free_clr;
    @(posedge CLK) disable iff (!RESETN || ABORT_RST)
      done && ctrl_q[`NVMAC_B_MSEL] |=> !ctrl_q[`NVMAC_B_FREE];
  endproperty
  a_free_clr: assert property (p_free_clr) else $error("row erase bit not cleared");
  property p_hold_fill;
    @(posedge CLK) disable iff (!RESETN || ABORT_RST)
      done && ctrl_q[`NVMAC_B_MSEL] && !ctrl_q[`NVMAC_B_FREE] |=> HOLD_DATA == {HOLD_BYTES{`NVMAC_HOLD_ERASED}};
  endproperty
  a_hold_fill: assert property (p_hold_fill) else $error("holding register not refilled");
  property p_key_clr;
    @(posedge CLK) disable iff (!RESETN) start |=> key_q == NVMAC_K_IDLE;
  endproperty
  a_key_clr: assert property (p_key_clr) else $error("unlock reused for second write");

  c_ee_write: cover property (@(posedge CLK) disable iff (!RESETN) EE_WRITE_START ##[1:300] done);
  c_erase: cover property (@(posedge CLK) disable iff (!RESETN) PGM_ERASE_START);
  c_pgm: cover property (@(posedge CLK) disable iff (!RESETN) PGM_WRITE_START);
  c_read: cover property (@(posedge CLK) disable iff (!RESETN) rd_go);
  c_abort: cover property (@(posedge CLK) disable iff (!RESETN) busy && ABORT_RST);
endmodule // nvmac_top
`default_nettype wire

// *** verification/nvmac_top_tb.sv ***
// Purpose: self-checking bench for the nonvolatile access controller
// Assumes: short self-timed write via WRITE_CYCLES, one register access at a time
// Notes:   xorshift stimulus from a fixed seed, corner cases among it
`timescale 1ns/1ns
`default_nettype none
`include "nvmac_defines.svh"
module nvmac_top_tb;
  localparam int WCYC = 12;
  logic        clk, resetn, abort_rst, sfr_we, tbl_rd, tbl_wr, busy, ee_ws, pg_ws, pg_es, dflag, dprio;
  logic [11:0] sfr_addr;
  logic [7:0]  sfr_wdata, sfr_rdata, pgm_rdata, ee_rdata, ee_wdata, v, d, a;
  logic [21:0] pgm_addr;
  logic [9:0]  ee_addr;
  logic [63:0] hold, exp_hold;
  logic [31:0] seed;
  int          miscompares, checks_done, bcnt, blen;
  int          n_ee = 0;
  int          n_pw = 0;
  int          n_pe = 0;

  nvmac_top #(.WRITE_CYCLES(WCYC)) DUT (.CLK(clk), .RESETN(resetn), .ABORT_RST(abort_rst),
    .SFR_ADDR(sfr_addr), .SFR_WE(sfr_we), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
    .TBL_RD(tbl_rd), .TBL_WR(tbl_wr), .PGM_ADDR(pgm_addr), .PGM_RDATA(pgm_rdata),
    .EE_RDATA(ee_rdata), .EE_ADDR(ee_addr), .EE_WDATA(ee_wdata), .NVM_BUSY(busy),
    .EE_WRITE_START(ee_ws), .PGM_WRITE_START(pg_ws), .PGM_ERASE_START(pg_es),
    .HOLD_DATA(hold), .WRITE_DONE_FLAG(dflag), .WRITE_DONE_PRIO(dprio));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // start pulses stand one cycle only, so they are counted at every edge
  always @(posedge clk) begin
    n_ee <= n_ee + int'(ee_ws === 1'b1);
    n_pw <= n_pw + int'(pg_ws === 1'b1);
    n_pe <= n_pe + int'(pg_es === 1'b1);
    if (busy === 1'b1) bcnt <= bcnt + 1;
    else if (bcnt != 0) begin
      blen <= bcnt;
      bcnt <= 0;
    end
  end

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] ad, input logic [7:0] dt);
    @(posedge clk);
    sfr_addr  <= ad;
    sfr_wdata <= dt;
    sfr_we    <= 1'b1;
    @(posedge clk);
    sfr_we    <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] ad, output logic [7:0] q);
    @(posedge clk);
    sfr_addr <= ad;
    @(negedge clk);
    q = sfr_rdata;
  endtask

  task automatic key(input logic [7:0] c);
    wr(`NVMAC_ADR_KEY, `NVMAC_KEY1);
    wr(`NVMAC_ADR_KEY, `NVMAC_KEY2);
    wr(`NVMAC_ADR_CTRL, c);
    @(negedge clk);
  endtask

  // bounded wait, a hung write shows up as a busy mismatch
  task automatic wait_idle();
    for (int i = 0; i < 4 * WCYC && busy === 1'b1; i++) @(negedge clk);
    chk(busy, 1'b0);
    // one more edge so the busy-length monitor has latched its count
    @(negedge clk);
  endtask

  task automatic close_out();
    if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    close_out();
  end

  initial begin
    resetn = 1'b0; abort_rst = 1'b0; sfr_we = 1'b0; tbl_rd = 1'b0; tbl_wr = 1'b0;
    sfr_addr = '0; sfr_wdata = '0; pgm_rdata = '0; ee_rdata = '0;
    seed = 32'h65CA; miscompares = 0; checks_done = 0; bcnt = 0; blen = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`NVMAC_ADR_PERIPHERAL_IRQ_PRIORITY_TWO, v); chk(v, `NVMAC_PERIPHERAL_IRQ_PRIORITY_TWO_RST);
    chk(dprio, `NVMAC_PERIPHERAL_IRQ_PRIORITY_TWO_RST >> `NVMAC_B_PRIO & 8'h01);
    rd(`NVMAC_ADR_CTRL, v); chk(v, 8'h00);
    rd(12'hFA0, v); chk(v, 8'h00);
    chk(hold, {64{1'b1}});
    for (int i = 0; i < 4; i++) begin
      a = rnd(); d = rnd(); v = rnd();
      wr(`NVMAC_ADR_ADRL, a); wr(`NVMAC_ADR_ADRH, v & 8'h03);
      ee_rdata <= d;
      @(negedge clk);
      chk(ee_addr, {v[1:0], a});
      wr(`NVMAC_ADR_CTRL, 8'h01);
      rd(`NVMAC_ADR_DATA, v); chk(v, d);
      rd(`NVMAC_ADR_CTRL, v); chk(v[0], 1'b0);
      ee_rdata <= ~d;
      rd(`NVMAC_ADR_DATA, v); chk(v, d);
    end
    a = rnd() & 8'hF8; d = rnd(); v = rnd();
    wr(`NVMAC_ADR_TPL, a); wr(`NVMAC_ADR_TPH, d); wr(`NVMAC_ADR_TPU, v);
    @(negedge clk);
    chk(pgm_addr, {v[5:0], d, a});
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      wr(`NVMAC_ADR_TPL, a | 8'(i));
      pgm_rdata <= d;
      @(posedge clk) tbl_rd <= 1'b1;
      @(posedge clk) tbl_rd <= 1'b0;
      rd(`NVMAC_ADR_TLAT, v); chk(v, d);
      @(posedge clk) tbl_wr <= 1'b1;
      @(posedge clk) tbl_wr <= 1'b0;
      exp_hold[8*i+:8] = d;
    end
    @(negedge clk);
    chk(hold, exp_hold);
    chk(n_pw, 0);
    key(8'h06); chk(busy, 1'b0);
    wr(`NVMAC_ADR_CTRL, 8'h00);
    key(8'h02); chk(busy, 1'b0);
    wr(`NVMAC_ADR_CTRL, 8'h04);
    wr(`NVMAC_ADR_KEY, `NVMAC_KEY1); wr(`NVMAC_ADR_DATA, 8'h00);
    wr(`NVMAC_ADR_KEY, `NVMAC_KEY2); wr(`NVMAC_ADR_CTRL, 8'h06);
    @(negedge clk); chk(busy, 1'b0);
    chk(n_ee, 0);
    d = rnd();
    wr(`NVMAC_ADR_DATA, d);
    key(8'h06); chk(busy, 1'b1);
    chk(n_ee, 1);
    chk(ee_wdata, d);
    wr(`NVMAC_ADR_DATA, ~d); wr(`NVMAC_ADR_CTRL, 8'h00); // locked, both ignored
    rd(`NVMAC_ADR_DATA, v); chk(v, d);
    chk(busy, 1'b1);
    wait_idle();
    chk(blen, WCYC);
    rd(`NVMAC_ADR_CTRL, v); chk(v[2:1], 2'b10);
    repeat (3) @(negedge clk);
    chk(dflag, 1'b1);
    wr(`NVMAC_ADR_PERIPHERAL_IRQ_PRIORITY_TWO, 8'h20); @(negedge clk);
    chk(dflag, 1'b0);
    chk(dprio, 1'b0);
    wr(`NVMAC_ADR_CTRL, 8'h84);
    key(8'h86); chk(n_pw, 1);
    chk(pgm_addr[2:0], 3'h0);
    wait_idle();
    chk(hold, {64{1'b1}});
    wr(`NVMAC_ADR_CTRL, 8'h94);
    key(8'h96); chk(n_pe, 1);
    chk(n_pw, 1);
    chk(pgm_addr[5:0], 6'h00);
    wait_idle();
    rd(`NVMAC_ADR_CTRL, v); chk(v[4], 1'b0);
    key(8'h86);
    @(posedge clk) abort_rst <= 1'b1;
    @(posedge clk) abort_rst <= 1'b0;
    @(negedge clk); chk(busy, 1'b0);
    rd(`NVMAC_ADR_CTRL, v); chk({v[7], v[3]}, 2'b11);
    close_out();
  end
endmodule // nvmac_top_tb
`default_nettype wire
